/* File: dv/cip_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Processor core model: instruction boundaries and returns
// ------------------------------------------------------------
module cip_core_model (
   input wire logic clk, // System clock.
   input wire logic rst_b, // Reset, active low.
   input wire logic slow, // Three-cycle instructions.
   input wire logic core_sleeping, // Core asleep.
   input wire logic ret_req, // Bench asks for a return.
   output logic instr_done, // Instruction boundary.
   output logic reti // Return pulse.
);
   logic [1:0] phase_r;
   // A sleeping core retires nothing; a slow core holds each instruction three cycles.
   assign instr_done = !core_sleeping && (!slow || phase_r == 2'h2);
   // The return is a single pulse so that one request gives one pop sequence.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         phase_r <= 2'h0;
         reti <= 1'b0;
      end else begin
         phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
         reti <= ret_req && !reti;
      end
   end
endmodule
`default_nettype wire

/* File: dv/cip_irq_prioritizer_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Port checker for the interrupt prioritizer
// ------------------------------------------------------------
module cip_prioritizer_checker #(
   parameter bit FLASH_GT_8K = 1'b1,
   parameter bit PC_WIDE = 1'b0
) (
   input wire logic clk, // System clock.
   input wire logic rst_b, // Reset, active low.
   input wire logic global_irq_enable, // Global enable.
   input wire logic instr_done, // Instruction boundary.
   input wire logic core_sleeping, // Core asleep.
   input wire logic ack, // Acknowledge pulse.
   input wire logic push_pc, // Push cycles.
   input wire logic jump, // Jump cycles.
   input wire logic pop_pc, // Pop cycles.
   input wire logic return_done, // Return finished.
   input wire cip_pkg::cip_levels_s levels // Executing levels.
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   // The jump and pop lengths depend on memory size and counter width.
   sequence s_jump;
      jump[*2] ##1 (jump == FLASH_GT_8K) ##1 !jump;
   endsequence
   sequence s_pop;
      pop_pc[*4] ##1 (pop_pc == PC_WIDE) ##1 !pop_pc;
   endsequence

   AST_ENTRY: assert property ($rose(push_pc) |-> push_pc[*2] ##1 !push_pc ##0 s_jump)
      else $error("entry push or jump length wrong");
   AST_FINISH: assert property (ack && !core_sleeping && !instr_done |=> !push_pc)
      else $error("push started before the instruction ended");
   AST_FINISH_BOUND: assert property (ack && !core_sleeping |-> ##[1:8] push_pc)
      else $error("push did not follow acknowledge");
   AST_WAKE: assert property (ack && core_sleeping |-> !push_pc[*6] ##[1:40] push_pc)
      else $error("wake latency wrong");
   AST_RET: assert property ($rose(pop_pc) |-> s_pop)
      else $error("return length wrong");
   AST_RET_DONE: assert property ($fell(pop_pc) |-> return_done)
      else $error("return finish pulse not right after the last pop");
   AST_NMI_GIE: assert property (ack && !$past(global_irq_enable) |-> levels.nmi)
      else $error("maskable acknowledge with global enable low");
   AST_NMI_BLOCK: assert property (levels.nmi |=> !ack)
      else $error("acknowledge during non-maskable handler");
   AST_HIGH_PREEMPT: assert property (ack && $past(levels.high) |-> levels.nmi)
      else $error("level one handler preempted by lower level");
   AST_RET_GAP: assert property (return_done && !instr_done ##1 !instr_done |-> !ack ##1 !ack)
      else $error("acknowledge before one instruction after return");
   AST_ACK_PULSE: assert property (ack |=> !ack)
      else $error("acknowledge longer than one cycle");
   AST_RET_LEVEL: assert property (return_done |-> levels == ($past(levels.nmi) ? ($past(levels) & 3'b011) :
      $past(levels.high) ? ($past(levels) & 3'b001) : 3'b000))
      else $error("return did not restore level state");
endmodule

bind cip_irq_prioritizer cip_prioritizer_checker #(.FLASH_GT_8K(FLASH_GT_8K), .PC_WIDE(PC_WIDE)) i_chk (
   .clk(clk), .rst_b(rst_b), .global_irq_enable(global_irq_enable), .instr_done(instr_done),
   .core_sleeping(core_sleeping), .ack(ack), .push_pc(push_pc), .jump(jump), .pop_pc(pop_pc),
   .return_done(return_done), .levels(levels));
`default_nettype wire

/* File: dv/test_cip_irq_prioritizer.sv */
`timescale 1ns/1ps
`default_nettype none
module test_cip_irq_prioritizer;
   logic clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, irq_cond, irq_en, q, mask, cv;
   logic gie, sleeping, slow, ret_req, instr_done, reti;
   logic ack, push_pc, jump, pop_pc, return_done;
   logic [7:0] ack_vector, last_vec;
   logic [15:0] vector_addr, va_app;
   cip_pkg::cip_levels_s levels, last_lv;
   int n_mismatch = 0;
   int check_count = 0;
   int n_ack = 0;
   int y, v;

   // Vector 2 is a second fixed non-maskable source, so two can compete.
   cip_irq_prioritizer #(.NMI_MASK(32'h0000_0006)) i_dut (.clk(clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq_cond(irq_cond), .peripheral_irq_enables(irq_en), .global_irq_enable(gie),
      .instr_done(instr_done), .core_sleeping(sleeping), .reti(reti), .ack(ack), .ack_vector(ack_vector),
      .vector_addr(vector_addr), .push_pc(push_pc), .jump(jump), .pop_pc(pop_pc),
      .return_done(return_done), .levels(levels));
   cip_core_model i_core (.clk(clk), .rst_b(rst_b), .slow(slow), .core_sleeping(sleeping),
      .ret_req(ret_req), .instr_done(instr_done), .reti(reti));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Record every acknowledge; sampled values avoid racing the design's updates.
   always @(posedge clk) begin
      if (ack === 1'b1) begin
         n_ack <= n_ack + 1;
         last_vec <= ack_vector;
         last_lv <= levels;
      end
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic close_out();
      if (n_mismatch == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // One APB transfer; an idle cycle follows so transfers never collide.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         n_mismatch++;
         close_out();
      end
      @(posedge clk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask

   task automatic wait_sig(ref logic s, input logic val);
      int i;
      i = 0;
      while (s !== val && i < 80) begin
         @(posedge clk);
         i++;
      end
      if (s !== val) begin
         n_mismatch++;
         close_out();
      end
   endtask

   // Waits for the next acknowledge, then for the entry to finish.
   task automatic wait_ack(input logic [7:0] ev, input logic [2:0] el);
      int k;
      k = n_ack;
      for (int i = 0; i < 80 && n_ack == k; i++) @(posedge clk);
      chk(32'(n_ack), 32'(k + 1));
      if (n_ack == k) close_out();
      chk(32'(last_vec), 32'(ev));
      chk(32'(last_lv), 32'(el));
      wait_sig(jump, 1'b1);
      wait_sig(jump, 1'b0);
   endtask

   task automatic ret(input logic [2:0] el);
      ret_req <= 1'b1;
      @(posedge clk);
      ret_req <= 1'b0;
      wait_sig(return_done, 1'b1);
      chk(32'(levels), 32'(el));
   endtask

   task automatic quiet(input int n);
      int k;
      k = n_ack;
      repeat (n) @(posedge clk);
      chk(32'(n_ack), 32'(k));
   endtask

   // The vector just after the lowest rank wins; ranks wrap around the table.
   function automatic int exp_norm(input logic [31:0] m, input int low);
      int w;
      w = 0;
      for (int k = 32; k >= 1; k--) begin
         if (m[(low + k) % 32]) w = (low + k) % 32;
      end
      return w;
   endfunction

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, gie, sleeping, slow, ret_req} = 7'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      irq_cond = 32'h0;
      irq_en = 32'h0;
      rst_b = 1'b0;
      void'($urandom(32'had35e977));
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd(cip_pkg::ADDR_CTRL, 32'h0);
      rd(cip_pkg::ADDR_STATUS, 32'h0);
      rd(cip_pkg::ADDR_NPRI, 32'h0);
      rd(cip_pkg::ADDR_HVEC, 32'h0);
      rd(12'h010, 32'h0);
      chk(32'(err), 32'h1);
      apb(1'b1, cip_pkg::ADDR_HVEC, 32'h7);
      irq_cond <= 32'h20;
      gie <= 1'b1;
      quiet(20);
      gie <= 1'b0;
      irq_en <= 32'h20;
      quiet(20);
      gie <= 1'b1;
      wait_ack(8'h05, 3'b001);
      irq_cond <= 32'ha0;
      irq_en <= 32'ha6;
      wait_ack(8'h07, 3'b011);
      gie <= 1'b0;
      irq_cond <= 32'ha6;
      wait_ack(8'h01, 3'b111);
      gie <= 1'b1;
      quiet(30);
      irq_cond <= 32'ha4;
      ret(3'b011);
      wait_ack(8'h02, 3'b111);
      irq_cond <= 32'ha0;
      ret(3'b011);
      ret(3'b001);
      wait_ack(8'h07, 3'b011);
      irq_cond <= 32'h0;
      ret(3'b001);
      ret(3'b000);
      // Static, rotating and compact tables, with random pending sets.
      for (int i = 0; i < 4; i++) begin
         y = 2 + ($urandom % 28);
         mask = ($urandom | (32'h1 << y)) & 32'hffff_ff78;
         cv = i[1] ? (32'h20 | (32'(i[0]) << 6)) : 32'(i[0]);
         apb(1'b1, cip_pkg::ADDR_CTRL, cv);
         apb(1'b1, cip_pkg::ADDR_NPRI, 32'(y));
         slow <= i[0];
         sleeping <= (i == 0);
         v = exp_norm(mask, y);
         irq_cond <= mask;
         irq_en <= mask;
         wait_ack(8'(v), 3'b001);
         sleeping <= 1'b0;
         if (i == 1) rd(cip_pkg::ADDR_NPRI, 32'(v));
         // Two words per vector; the compact table sends every normal request to one slot.
         va_app = (i == 3 ? 16'h0000 : 16'h0200) + 16'h0002 * (i[1] ? cip_pkg::CVT_NORM_VEC : 8'(v));
         chk(32'(vector_addr), 32'(va_app));
         irq_cond <= 32'h0;
         ret(3'b000);
      end
      close_out();
   end
endmodule
`default_nettype wire

/* File: src/cip_irq_prioritizer.sv */
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cip_irq_prioritizer #(
   parameter int unsigned NVEC = 32,
   parameter int unsigned ADDR_W = 16,
   parameter logic [31:0] NMI_MASK = 32'h0000_0002,
   parameter logic [15:0] APP_BASE = 16'h0200,
   parameter logic [15:0] BOOT_BASE = 16'h0000,
   parameter bit FLASH_GT_8K = 1'b1,
   parameter bit PC_WIDE = 1'b0,
   parameter int unsigned SLEEP_STARTUP = 0
) (
   input wire logic clk, // System clock.
   input wire logic rst_b, // Asynchronous reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction.
   input wire logic [11:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error for unmapped address.
   input wire logic [NVEC-1:0] irq_cond, // Peripheral interrupt conditions.
   input wire logic [NVEC-1:0] peripheral_irq_enables, // Peripheral line enables.
   input wire logic global_irq_enable, // Global enable bit of core_status_word.
   input wire logic instr_done, // Current instruction ends this cycle.
   input wire logic core_sleeping, // Core is in a sleep mode.
   input wire logic reti, // Core executes a handler return.
   output logic ack, // One-cycle acknowledge of the winning vector.
   output logic [7:0] ack_vector, // Vector number acknowledged.
   output logic [ADDR_W-1:0] vector_addr, // Handler vector address.
   output logic push_pc, // Program counter push cycles.
   output logic jump, // Jump to handler cycles.
   output logic pop_pc, // Program counter pop cycles.
   output logic return_done, // Return finished, one-cycle pulse.
   output cip_pkg::cip_levels_s levels // Executing levels.
);

   // ------------------------------------------------------------
   // Derived counts
   // ------------------------------------------------------------
   localparam int unsigned JUMP_CYC = FLASH_GT_8K ? cip_pkg::JUMP_LONG_CYC : cip_pkg::JUMP_SHORT_CYC;
   localparam int unsigned RET_CYC = PC_WIDE ? cip_pkg::RET_LONG_CYC : cip_pkg::RET_SHORT_CYC;
   localparam int unsigned WAKE_CYC = cip_pkg::FINISH_CYC + cip_pkg::WAKE_EXTRA_CYC + SLEEP_STARTUP;
   localparam logic [15:0] PUSH_LOAD = 16'(cip_pkg::PUSH_CYC - 1);
   localparam logic [15:0] JUMP_LOAD = 16'(JUMP_CYC - 1);
   localparam logic [15:0] RET_LOAD = 16'(RET_CYC - 1);
   localparam logic [15:0] WAKE_LOAD = 16'(WAKE_CYC - 1);
   localparam logic [ADDR_W-1:0] VEC_WORDS = ADDR_W'(FLASH_GT_8K ? 2 : 1);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   cip_pkg::cip_state_e state_r;
   cip_pkg::cip_state_e state_nxt;
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   logic hold_one_r;
   logic base_sel_r;
   logic compact_r;
   logic rotate_r;
   logic [7:0] npri_r;
   logic [7:0] hvec_r;
   cip_pkg::cip_levels_s lvl_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic ack_r;
   logic [7:0] ack_vector_r;
   logic [ADDR_W-1:0] vector_addr_r;
   logic push_pc_r;
   logic jump_r;
   logic pop_pc_r;
   logic return_done_r;

   // ------------------------------------------------------------
   // Request formation
   // ------------------------------------------------------------
   // Requests are plain levels; flags are owned and cleared by the peripherals.
   wire [NVEC-1:0] req = irq_cond & peripheral_irq_enables & ~NVEC'(1);
   wire [NVEC-1:0] nmi_req = req & NMI_MASK[NVEC-1:0];
   wire [NVEC-1:0] mask_req = req & ~NMI_MASK[NVEC-1:0];
   wire hvec_ok = hvec_r < 8'(NVEC);
   wire [NVEC-1:0] hvec_onehot = hvec_ok ? (NVEC'(1) << hvec_r) : '0;
   wire high_hit = |(mask_req & hvec_onehot);
   wire [NVEC-1:0] norm_req = mask_req & ~hvec_onehot;

   // ------------------------------------------------------------
   // Vector search
   // ------------------------------------------------------------
   logic nmi_found;
   logic [7:0] nmi_vec;
   logic norm_found;
   logic [7:0] norm_vec;

   // Fixed order for non-maskable sources, lowest number first.
   always_comb begin
      nmi_found = 1'b0;
      nmi_vec = 8'h00;
      for (int i = NVEC - 1; i >= 0; i--) begin
         if (nmi_req[i]) begin
            nmi_found = 1'b1;
            nmi_vec = 8'(i);
         end
      end
   end

   // Level zero search starts just above the lowest rank and wraps round.
   // The modulo keeps it correct for any table size, at some area cost.
   always_comb begin
      int idx;
      idx = 0;
      norm_found = 1'b0;
      norm_vec = 8'h00;
      for (int k = 1; k <= NVEC; k++) begin
         idx = (int'(npri_r) + k) % NVEC;
         if (!norm_found && norm_req[idx]) begin
            norm_found = 1'b1;
            norm_vec = 8'(idx);
         end
      end
   end

   // ------------------------------------------------------------
   // Level arbitration
   // ------------------------------------------------------------
   // A running non-maskable handler blocks everything, itself included.
   wire take_nmi = nmi_found && !lvl_r.nmi;
   wire take_high = high_hit && global_irq_enable && !lvl_r.nmi && !lvl_r.high && !take_nmi;
   wire lvl_idle = !lvl_r.nmi && !lvl_r.high && !lvl_r.norm;
   wire take_norm = norm_found && global_irq_enable && lvl_idle && !take_nmi && !take_high;
   wire win_valid = take_nmi || take_high || take_norm;
   wire [7:0] win_vec = take_nmi ? nmi_vec : (take_high ? hvec_r : norm_vec);

   // Compact table collapses each level onto one shared handler per level: vectors 1, 2 and 3.
   wire [7:0] cvt_vec = take_nmi ? cip_pkg::CVT_NMI_VEC :
                        (take_high ? cip_pkg::CVT_HIGH_VEC : cip_pkg::CVT_NORM_VEC);
   wire [7:0] table_vec = compact_r ? cvt_vec : win_vec;
   wire [ADDR_W-1:0] base_addr = base_sel_r ? BOOT_BASE[ADDR_W-1:0] : APP_BASE[ADDR_W-1:0];
   wire [ADDR_W-1:0] win_addr = ADDR_W'(base_addr + ADDR_W'(table_vec) * VEC_WORDS);

   // A return in the same cycle outranks a new acknowledge.
   wire in_idle = state_r == cip_pkg::ST_IDLE;
   wire take_ret = in_idle && reti;
   wire take_ack = in_idle && !reti && win_valid && !hold_one_r;
   wire ret_end = state_r == cip_pkg::ST_RET && cnt_r == 16'h0000;

   // ------------------------------------------------------------
   // Entry and return sequencer
   // ------------------------------------------------------------
   // Timed states count down by default and act only when the count reaches zero.
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = (cnt_r == 16'h0000) ? cnt_r : cnt_r - 16'h0001;
      case (state_r)
         cip_pkg::ST_IDLE: begin
            if (take_ret) begin
               state_nxt = cip_pkg::ST_RET;
               cnt_nxt = RET_LOAD;
            end else if (take_ack && core_sleeping) begin
               state_nxt = cip_pkg::ST_WAKE;
               cnt_nxt = WAKE_LOAD;
            end else if (take_ack) begin
               state_nxt = cip_pkg::ST_FINISH;
            end
         end
         cip_pkg::ST_WAKE: begin
            if (cnt_r == 16'h0000) begin
               state_nxt = cip_pkg::ST_PUSH;
               cnt_nxt = PUSH_LOAD;
            end
         end
         cip_pkg::ST_FINISH: begin
            if (instr_done) begin
               state_nxt = cip_pkg::ST_PUSH;
               cnt_nxt = PUSH_LOAD;
            end
         end
         cip_pkg::ST_PUSH: begin
            if (cnt_r == 16'h0000) begin
               state_nxt = cip_pkg::ST_JUMP;
               cnt_nxt = JUMP_LOAD;
            end
         end
         cip_pkg::ST_JUMP: begin
            if (cnt_r == 16'h0000) begin
               state_nxt = cip_pkg::ST_IDLE;
            end
         end
         cip_pkg::ST_RET: begin
            if (cnt_r == 16'h0000) begin
               state_nxt = cip_pkg::ST_IDLE;
            end
         end
         default: begin
            state_nxt = cip_pkg::ST_IDLE;
            cnt_nxt = 16'h0000;
         end
      endcase
   end

   // Sequencer state.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= cip_pkg::ST_IDLE;
         cnt_r <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // One instruction must retire after a return before the next entry.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hold_one_r <= 1'b0;
      end else if (ret_end) begin
         hold_one_r <= 1'b1;
      end else if (in_idle && instr_done) begin
         hold_one_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Executing level tracking
   // ------------------------------------------------------------
   // A return always unwinds the highest active level, which is the
   // one that was entered last since lower levels never preempt.
   cip_pkg::cip_levels_s lvl_set;
   cip_pkg::cip_levels_s lvl_clr;
   assign lvl_set = '{nmi: take_ack && take_nmi, high: take_ack && take_high, norm: take_ack && take_norm};
   assign lvl_clr = '{nmi: ret_end && lvl_r.nmi,
                      high: ret_end && !lvl_r.nmi && lvl_r.high,
                      norm: ret_end && !lvl_r.nmi && !lvl_r.high && lvl_r.norm};

   // ------------------------------------------------------------
   // Core side outputs
   // ------------------------------------------------------------
   // Phase strobes follow the next state so they line up with it; levels move with ack.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_r <= 1'b0;
         ack_vector_r <= 8'h00;
         vector_addr_r <= '0;
         push_pc_r <= 1'b0;
         jump_r <= 1'b0;
         pop_pc_r <= 1'b0;
         return_done_r <= 1'b0;
         lvl_r <= '0;
      end else begin
         ack_r <= take_ack;
         if (take_ack) begin
            ack_vector_r <= win_vec;
            vector_addr_r <= win_addr;
         end
         push_pc_r <= state_nxt == cip_pkg::ST_PUSH;
         jump_r <= state_nxt == cip_pkg::ST_JUMP;
         pop_pc_r <= state_nxt == cip_pkg::ST_RET;
         return_done_r <= ret_end;
         lvl_r <= (lvl_r & ~lvl_clr) | lvl_set;
      end
   end

   // ------------------------------------------------------------
   // APB register file
   // ------------------------------------------------------------
   wire setup = psel && !penable;
   wire wr_en = psel && penable && pwrite && pready_r;
   wire aligned = paddr[1:0] == 2'b00;
   wire hit_ctrl = aligned && paddr == cip_pkg::ADDR_CTRL;
   wire hit_status = aligned && paddr == cip_pkg::ADDR_STATUS;
   wire hit_npri = aligned && paddr == cip_pkg::ADDR_NPRI;
   wire hit_hvec = aligned && paddr == cip_pkg::ADDR_HVEC;
   wire hit_any = hit_ctrl || hit_status || hit_npri || hit_hvec;
   wire [7:0] ctrl_rd = 8'(base_sel_r) << cip_pkg::CTRL_BASE_BIT |
                        8'(compact_r) << cip_pkg::CTRL_COMPACT_BIT |
                        8'(rotate_r) << cip_pkg::CTRL_ROTATE_BIT;
   wire [7:0] status_rd = 8'(lvl_r.nmi) << cip_pkg::STAT_NMI_BIT |
                          8'(lvl_r.high) << cip_pkg::STAT_HIGH_BIT |
                          8'(lvl_r.norm) << cip_pkg::STAT_NORM_BIT;
   wire [7:0] rd_byte = hit_ctrl ? ctrl_rd :
                        hit_status ? status_rd :
                        hit_npri ? npri_r :
                        hit_hvec ? hvec_r : 8'h00;
   wire rotate_load = take_ack && take_norm && rotate_r;

   // Answer in the access phase with no wait state.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= setup;
         pslverr_r <= setup && !hit_any;
         prdata_r <= setup ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // Hardware rotation wins over a software write in the same cycle.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         base_sel_r <= cip_pkg::CTRL_RESET[cip_pkg::CTRL_BASE_BIT];
         compact_r <= cip_pkg::CTRL_RESET[cip_pkg::CTRL_COMPACT_BIT];
         rotate_r <= cip_pkg::CTRL_RESET[cip_pkg::CTRL_ROTATE_BIT];
         npri_r <= cip_pkg::NPRI_RESET;
         hvec_r <= cip_pkg::HVEC_RESET;
      end else begin
         if (wr_en && hit_ctrl) begin
            base_sel_r <= pwdata[cip_pkg::CTRL_BASE_BIT];
            compact_r <= pwdata[cip_pkg::CTRL_COMPACT_BIT];
            rotate_r <= pwdata[cip_pkg::CTRL_ROTATE_BIT];
         end
         if (rotate_load) begin
            npri_r <= win_vec;
         end else if (wr_en && hit_npri) begin
            npri_r <= pwdata[7:0];
         end
         if (wr_en && hit_hvec) begin
            hvec_r <= pwdata[7:0];
         end
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign ack = ack_r;
   assign ack_vector = ack_vector_r;
   assign vector_addr = vector_addr_r;
   assign push_pc = push_pc_r;
   assign jump = jump_r;
   assign pop_pc = pop_pc_r;
   assign return_done = return_done_r;
   assign levels = lvl_r;

endmodule
`default_nettype wire

/* File: src/cip_pkg.sv */
// Functional notes
// - Rank each request against running levels; acknowledge now or keep it pending.
// - After a return, run one more instruction before serving pending requests.
// - Global enable gates all maskable requests; one enables, zero disables.
// - A request counts only when peripheral enable and condition are both set.
// - Handler entry never clears any peripheral interrupt flag.
// - Vector base chosen between application and boot area by select bit.
// - Entry takes one finish cycle, two push cycles, three or two jump cycles.
// - A multi-cycle instruction completes before entry begins.
// - Wake from sleep adds five cycles plus sleep start-up time.
// - Return pops program counter over four or five cycles.
// - Non-maskable over level one over level zero; level one preempts level zero.
// - Only one vector can be promoted to level one.
// - Non-maskable requests ignore global enable and never touch it.
// - Nothing preempts a running non-maskable handler.
// - Concurrent non-maskable requests: lowest vector number wins.
// - Non-maskable sources are fixed in hardware, still enabled at their origin.
// - The high level vector register names the single level-one request.
// - Level zero ranks start just above the lowest rank register, wrapping.
// - Round-robin loads the lowest rank register with each acknowledged level zero vector.
// - Compact table maps non-maskable, level one, level zero to vectors 1, 2, 3.
package cip_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam int unsigned IDX_CTRL = 0;
   localparam int unsigned IDX_STATUS = 1;
   localparam int unsigned IDX_NPRI = 2;
   localparam int unsigned IDX_HVEC = 3;
   localparam logic [11:0] ADDR_CTRL = 12'(IDX_CTRL * 4);
   localparam logic [11:0] ADDR_STATUS = 12'(IDX_STATUS * 4);
   localparam logic [11:0] ADDR_NPRI = 12'(IDX_NPRI * 4);
   localparam logic [11:0] ADDR_HVEC = 12'(IDX_HVEC * 4);

   localparam int unsigned CTRL_BASE_BIT = 6;
   localparam int unsigned CTRL_COMPACT_BIT = 5;
   localparam int unsigned CTRL_ROTATE_BIT = 0;
   localparam int unsigned STAT_NMI_BIT = 7;
   localparam int unsigned STAT_HIGH_BIT = 1;
   localparam int unsigned STAT_NORM_BIT = 0;

   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] NPRI_RESET = 8'h00;
   localparam logic [7:0] HVEC_RESET = 8'h00;

   // ------------------------------------------------------------
   // Timing counts in clock cycles
   // ------------------------------------------------------------
   localparam int unsigned FINISH_CYC = 1;
   localparam int unsigned PUSH_CYC = 2;
   localparam int unsigned JUMP_LONG_CYC = 3;
   localparam int unsigned JUMP_SHORT_CYC = 2;
   localparam int unsigned WAKE_EXTRA_CYC = 5;
   localparam int unsigned RET_SHORT_CYC = 4;
   localparam int unsigned RET_LONG_CYC = 5;

   // ------------------------------------------------------------
   // Compact table vectors
   // ------------------------------------------------------------
   localparam logic [7:0] CVT_NMI_VEC = 8'h01;
   localparam logic [7:0] CVT_HIGH_VEC = 8'h02;
   localparam logic [7:0] CVT_NORM_VEC = 8'h03;

   typedef struct packed {
      logic nmi;
      logic high;
      logic norm;
   } cip_levels_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WAKE = 3'b001,
      ST_FINISH = 3'b010,
      ST_PUSH = 3'b011,
      ST_JUMP = 3'b100,
      ST_RET = 3'b101
   } cip_state_e;

endpackage
